// ===== pkg/fbp_pkg.sv
// Constants and types for the flash block protection logic
package fbp_pkg;
   // Array geometry: 32 KB of 32-bit words, 1 KB erase blocks
   localparam int FBP_WORD_AW = 13;
   localparam int FBP_WORDS = 8192;
   localparam int FBP_BLK_AW = 5;
   localparam int FBP_BLKS = 32;
   localparam int FBP_BLK_WORDS = 256;
   localparam int FBP_OFF_AW = 8;
   localparam int FBP_UNIT_AW = 4;
   localparam int FBP_UNITS = 16;
   localparam int FBP_DW = 32;
   // Erased state of a word
   localparam logic [31:0] FBP_ERASED = 32'hFFFFFFFF;
   localparam logic [31:0] FBP_ZERO = 32'h00000000;
   // Protection codes per 2 KB unit
   localparam logic [1:0] FBP_PROT_NONE = 2'h0;
   localparam logic [1:0] FBP_PROT_RO = 2'h1;
   localparam logic [1:0] FBP_PROT_XO = 2'h2;
   localparam logic [31:0] FBP_PROT_RST = 32'h00000000;
   // Read requester codes
   localparam logic [1:0] FBP_SRC_FETCH = 2'h0;
   localparam logic [1:0] FBP_SRC_DATA = 2'h1;
   localparam logic [1:0] FBP_SRC_DBG = 2'h2;

   typedef enum logic [2:0] {
      FBP_IDLE = 3'b001,
      FBP_ERASE = 3'b010,
      FBP_DONE = 3'b100
   } fbp_state_t;
endpackage

// ===== hdl/fbp_mem.sv
// Flash array storage with registered read data and word write port
`timescale 1ns/1ns
module fbp_mem
   import fbp_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Read port
   input wire logic [FBP_WORD_AW-1:0] rd_addr_i,
   input wire logic rd_clr_i,
   output logic [FBP_DW-1:0] rd_data_o,
   // Write port
   input wire logic wr_en_i,
   input wire logic [FBP_WORD_AW-1:0] wr_addr_i,
   input wire logic [FBP_DW-1:0] wr_data_i
);
   // No reset: array contents persist like real flash
   logic [FBP_DW-1:0] mem_ff [FBP_WORDS];

   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
      // Refused reads load zero so the array never reaches the port
      if (rd_clr_i) begin
         rd_data_o <= FBP_ZERO;
      end else begin
         rd_data_o <= mem_ff[rd_addr_i];
      end
   end
endmodule

// ===== hdl/fbp_top.sv
// Flash block protection: access control, erase and program of the array
//
// Behaviour
// - 32 KB array in 1 KB blocks; each block erases on its own.
// - After a block erase every bit of that block reads one.
// - Protection per 2 KB unit of two blocks, each unit independent.
// - Unit is open, read-only or execute-only; checks use addressed unit.
// - Read-only unit refuses erase and program; reads still allowed.
// - Execute-only unit refuses erase and program.
// - Execute-only unit answers only instruction fetches, not data or debug.
// - Permitted reads complete in one clock cycle, no wait states.
`timescale 1ns/1ns
module fbp_top
   import fbp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Protection setup, two bits per 2 KB unit
   input wire logic prot_wr_i,
   input wire logic [31:0] prot_cfg_i,
   output logic [31:0] prot_cfg_o,
   // Read request
   input wire logic rd_req_i,
   input wire logic [1:0] rd_src_i,
   input wire logic [FBP_WORD_AW-1:0] rd_addr_i,
   output logic rd_ack_o,
   output logic rd_deny_o,
   output logic [FBP_DW-1:0] rd_data_o,
   // Program and erase commands
   input wire logic prog_req_i,
   input wire logic [FBP_WORD_AW-1:0] prog_addr_i,
   input wire logic [FBP_DW-1:0] prog_data_i,
   input wire logic erase_req_i,
   input wire logic [FBP_BLK_AW-1:0] erase_blk_i,
   output logic busy_o,
   output logic op_done_o,
   output logic op_deny_o,
   // Sticky violation flag
   input wire logic viol_clr_i,
   output logic viol_o
);
   fbp_state_t state_ff, nxt_state;
   logic [31:0] prot_ff, nxt_prot;
   logic [FBP_BLK_AW-1:0] blk_ff, nxt_blk;
   logic [FBP_OFF_AW-1:0] off_ff, nxt_off;
   logic rd_ack_ff, nxt_rd_ack;
   logic rd_deny_ff, nxt_rd_deny;
   logic done_ff, nxt_done;
   logic odeny_ff, nxt_odeny;
   logic viol_ff, nxt_viol;
   logic busy_ff, nxt_busy;
   logic [FBP_DW-1:0] mem_q;
   logic mem_we;
   logic [FBP_WORD_AW-1:0] mem_wa;
   logic [FBP_DW-1:0] mem_wd;
   logic [FBP_UNITS-1:0] unit_wp;
   logic [FBP_UNITS-1:0] unit_xo;
   logic rd_bad, prog_bad, erase_bad;

   // One decode slice per 2 KB unit
   genvar gu;
   generate
      for (gu = 0; gu < FBP_UNITS; gu++) begin : g_unit
         assign unit_xo[gu] = prot_ff[2*gu +: 2] == FBP_PROT_XO;
         assign unit_wp[gu] = (prot_ff[2*gu +: 2] == FBP_PROT_RO) ||
                              unit_xo[gu];
      end
   endgenerate

   // Unit index is the top four word-address bits
   assign rd_bad = unit_xo[rd_addr_i[FBP_WORD_AW-1 -: FBP_UNIT_AW]] &&
                   (rd_src_i != FBP_SRC_FETCH);
   assign prog_bad = unit_wp[prog_addr_i[FBP_WORD_AW-1 -: FBP_UNIT_AW]];
   assign erase_bad = unit_wp[erase_blk_i[FBP_BLK_AW-1 -: FBP_UNIT_AW]];

   // Refused reads are zeroed in the memory's own output register
   fbp_mem fbp_mem_i (
      .clk_sys_i(clk_sys_i),
      .rd_addr_i(rd_addr_i),
      .rd_clr_i(nxt_rd_deny),
      .rd_data_o(mem_q),
      .wr_en_i(mem_we),
      .wr_addr_i(mem_wa),
      .wr_data_i(mem_wd)
   );

   // Command sequencing; erase walks one word per cycle through the block
   always_comb begin
      nxt_state = state_ff;
      nxt_prot = prot_ff;
      nxt_blk = blk_ff;
      nxt_off = off_ff;
      nxt_done = 1'b0;
      nxt_odeny = 1'b0;
      mem_we = 1'b0;
      mem_wa = prog_addr_i;
      mem_wd = prog_data_i;
      // Setup only accepted while idle so an erase cannot change rights midway
      if (prot_wr_i && state_ff == FBP_IDLE) begin
         nxt_prot = prot_cfg_i;
      end
      case (state_ff)
         FBP_IDLE: begin
            if (erase_req_i) begin
               if (erase_bad) begin
                  nxt_odeny = 1'b1;
                  nxt_done = 1'b1;
               end else begin
                  nxt_blk = erase_blk_i;
                  nxt_off = '0;
                  nxt_state = FBP_ERASE;
               end
            end else if (prog_req_i) begin
               nxt_done = 1'b1;
               if (prog_bad) begin
                  nxt_odeny = 1'b1;
               end else begin
                  mem_we = 1'b1;
               end
            end
         end
         FBP_ERASE: begin
            mem_we = 1'b1;
            mem_wa = {blk_ff, off_ff};
            mem_wd = FBP_ERASED;
            nxt_off = off_ff + 1'b1;
            if (off_ff == FBP_OFF_AW'(FBP_BLK_WORDS - 1)) begin
               nxt_state = FBP_DONE;
            end
         end
         FBP_DONE: begin
            nxt_done = 1'b1;
            nxt_state = FBP_IDLE;
         end
         default: begin
            nxt_state = FBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= FBP_IDLE;
         prot_ff <= FBP_PROT_RST;
         blk_ff <= '0;
         off_ff <= '0;
         done_ff <= 1'b0;
         odeny_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         prot_ff <= nxt_prot;
         blk_ff <= nxt_blk;
         off_ff <= nxt_off;
         done_ff <= nxt_done;
         odeny_ff <= nxt_odeny;
      end
   end

   // Busy has its own flop so the port is a clean register output;
   // it is high from the edge taking an erase to the edge of op_done
   always_comb begin
      nxt_busy = (nxt_state != FBP_IDLE);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_busy;
      end
   end

   // Read answer; reads are served during an erase and may see a
   // half-erased block, so software must not read it meanwhile
   always_comb begin
      nxt_rd_ack = rd_req_i;
      nxt_rd_deny = rd_req_i && rd_bad;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ack_ff <= 1'b0;
         rd_deny_ff <= 1'b0;
      end else begin
         rd_ack_ff <= nxt_rd_ack;
         rd_deny_ff <= nxt_rd_deny;
      end
   end

   // Sticky violation flag, raised by any refused read, program or
   // erase; only viol_clr_i or rst_i lowers it
   always_comb begin
      nxt_viol = viol_ff;
      if (viol_clr_i) begin
         nxt_viol = 1'b0;
      end
      // A new violation wins over a clear so no event is lost
      if (nxt_rd_deny || nxt_odeny) begin
         nxt_viol = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         viol_ff <= 1'b0;
      end else begin
         viol_ff <= nxt_viol;
      end
   end

   // Denied reads were zeroed inside the memory's output register,
   // which keeps the answer single cycle and straight from a flop
   assign rd_data_o = mem_q;
   assign rd_ack_o = rd_ack_ff;
   assign rd_deny_o = rd_deny_ff;
   assign prot_cfg_o = prot_ff;
   assign busy_o = busy_ff;
   assign op_done_o = done_ff;
   assign op_deny_o = odeny_ff;
   assign viol_o = viol_ff;
endmodule

// ===== test/fbp_top_sva.sv
// Port assertions for the flash block protection logic
`timescale 1ns/1ns
module fbp_top_sva import fbp_pkg::*; (
   // Clock, reset and protection
   input wire logic clk_sys_i, rst_i,
   input wire logic [31:0] prot_cfg_o,
   // Reads
   input wire logic rd_req_i, rd_ack_o, rd_deny_o,
   input wire logic [1:0] rd_src_i,
   input wire logic [12:0] rd_addr_i, prog_addr_i,
   input wire logic [31:0] rd_data_o,
   // Program, erase and violation flag
   input wire logic prog_req_i, erase_req_i, busy_o, op_done_o, op_deny_o,
   input wire logic [4:0] erase_blk_i,
   input wire logic viol_clr_i, viol_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic [1:0] rp, pp, ep;
   logic pl, el, go;
   // Protection of the unit each request addresses
   assign rp = prot_cfg_o[{rd_addr_i[12:9], 1'b0} +: 2];
   assign pp = prot_cfg_o[{prog_addr_i[12:9], 1'b0} +: 2];
   assign ep = prot_cfg_o[{erase_blk_i[4:1], 1'b0} +: 2];
   assign pl = pp inside {FBP_PROT_RO, FBP_PROT_XO};
   assign el = ep inside {FBP_PROT_RO, FBP_PROT_XO};
   assign go = !busy_o && !erase_req_i;
   read_ack_a: assert property (rd_req_i |=> rd_ack_o)
      else $error("read not answered");
   ack_cause_a: assert property (!rd_req_i |=> !rd_ack_o)
      else $error("stray read answer");
   xo_deny_a: assert property (rd_req_i && rd_src_i != FBP_SRC_FETCH &&
      rp == FBP_PROT_XO |=> rd_deny_o && rd_data_o == FBP_ZERO)
      else $error("hidden read served");
   read_open_a: assert property (rd_req_i && (rd_src_i == FBP_SRC_FETCH
      || rp != FBP_PROT_XO) |=> !rd_deny_o)
      else $error("legal read refused");
   deny_flag_a: assert property (rd_deny_o || op_deny_o |-> viol_o)
      else $error("violation not flagged");
   viol_hold_a: assert property (viol_o && !viol_clr_i |=> viol_o)
      else $error("violation flag lost");
   clr_drop_a: assert property (viol_clr_i && !rd_req_i &&
      !prog_req_i && !erase_req_i |=> !viol_o)
      else $error("violation flag not cleared");
   prog_deny_a: assert property (prog_req_i && go && pl
      |=> op_done_o && op_deny_o) else $error("locked program taken");
   prog_ok_a: assert property (prog_req_i && go && !pl
      |=> op_done_o && !op_deny_o) else $error("open program refused");
   erase_run_a: assert property (erase_req_i && !busy_o && !el
      |=> busy_o ##257 (op_done_o && !busy_o)) else $error("erase length");
   erase_deny_a: assert property (erase_req_i && !busy_o && el
      |=> op_deny_o && !busy_o) else $error("locked erase taken");
   cover property (rd_deny_o);
   cover property (op_done_o && op_deny_o);
   cover property (busy_o ##1 op_done_o);
   cover property (viol_o && viol_clr_i);
endmodule
bind fbp_top fbp_top_sva fbp_top_sva_i (.clk_sys_i, .rst_i, .prot_cfg_o,
   .rd_req_i, .rd_ack_o, .rd_deny_o, .rd_src_i, .rd_addr_i, .prog_addr_i,
   .rd_data_o, .prog_req_i, .erase_req_i, .busy_o, .op_done_o, .op_deny_o,
   .erase_blk_i, .viol_clr_i, .viol_o);

// ===== test/fbp_host.sv
// Fetch, data and debug read requester facing the flash block
`timescale 1ns/1ns
module fbp_host import fbp_pkg::*; (
   // Clock
   input wire logic clk_sys_i,
   // Read request
   output logic rd_req_o = 1'b0,
   output logic [1:0] rd_src_o = FBP_SRC_FETCH,
   output logic [12:0] rd_addr_o = 13'h0000
);
   // Address is inverted after the request so no stale value lingers
   task automatic rd(input logic [1:0] s, input logic [12:0] a);
      @(negedge clk_sys_i);
      rd_req_o = 1'b1;
      rd_src_o = s;
      rd_addr_o = a;
      @(negedge clk_sys_i);
      rd_req_o = 1'b0;
      rd_addr_o = ~a;
   endtask
endmodule

// ===== test/test_flash_block_protection.sv
// Self-checking bench for the flash block protection logic
`timescale 1ns/1ns
module test_flash_block_protection import fbp_pkg::*;;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, prot_wr_i = 1'b0, prog_req_i = 1'b0;
   logic erase_req_i = 1'b0, viol_clr_i = 1'b0;
   logic [31:0] prot_cfg_i = '0, prog_data_i = '0, prot_cfg_o, rd_data_o;
   logic [12:0] prog_addr_i = '0, rd_addr_i;
   logic [4:0] erase_blk_i = '0;
   logic [1:0] rd_src_i;
   logic rd_req_i, rd_ack_o, rd_deny_o, busy_o, op_done_o, op_deny_o, viol_o;
   int miscompares = 0, checked = 0, cycles = 0;
   fbp_top fbp_top_i (.clk_sys_i, .rst_i, .prot_wr_i, .prot_cfg_i,
      .prot_cfg_o, .rd_req_i, .rd_src_i, .rd_addr_i, .rd_ack_o, .rd_deny_o,
      .rd_data_o, .prog_req_i, .prog_addr_i, .prog_data_i, .erase_req_i,
      .erase_blk_i, .busy_o, .op_done_o, .op_deny_o, .viol_clr_i, .viol_o);
   fbp_host fbp_host_i (.clk_sys_i, .rd_req_o(rd_req_i),
      .rd_src_o(rd_src_i), .rd_addr_o(rd_addr_i));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(logic [1:0] s, logic [12:0] a, logic [31:0] d, logic n);
      fbp_host_i.rd(s, a);
      chk({rd_ack_o, rd_deny_o}, {1'b1, n});
      chk(rd_data_o, d);
   endtask
   task automatic prog(logic [12:0] a, logic [31:0] d, logic n);
      @(negedge clk_sys_i);
      prog_req_i = 1'b1;
      prog_addr_i = a;
      prog_data_i = d;
      @(negedge clk_sys_i);
      prog_req_i = 1'b0;
      chk({op_done_o, op_deny_o}, {1'b1, n});
   endtask
   task automatic setp(logic [31:0] c);
      @(negedge clk_sys_i);
      prot_wr_i = 1'b1;
      prot_cfg_i = c;
      @(negedge clk_sys_i);
      prot_wr_i = 1'b0;
      chk(prot_cfg_o, c);
   endtask
   // Counts cycles to completion; a refused erase must end at once
   task automatic erase(logic [4:0] b, logic n);
      int k;
      @(negedge clk_sys_i);
      erase_req_i = 1'b1;
      erase_blk_i = b;
      @(negedge clk_sys_i);
      erase_req_i = 1'b0;
      chk(busy_o, !n);
      for (k = 1; op_done_o !== 1'b1 && k < 300; k++)
         @(negedge clk_sys_i);
      chk({op_deny_o, 31'(k)}, {n, n ? 31'h1 : 31'h102});
   endtask
   // Every unit open after reset: a debug read returns what was written
   task automatic t_open();
      prog(13'h0005, 32'hA5A5_0001, 1'b0);
      prog(13'h0105, 32'h5A5A_0002, 1'b0);
      prog(13'h0205, 32'h1234_0003, 1'b0);
      prog(13'h0405, 32'hC3C3_0004, 1'b0);
      rd(FBP_SRC_DBG, 13'h0405, 32'hC3C3_0004, 1'b0);
      $display("open unit test done");
   endtask
   // Unit 1 read-only, unit 2 execute-only, unit 0 stays open
   task automatic t_ro();
      setp(32'h0000_0024);
      prog(13'h0205, 32'h0, 1'b1);
      erase(5'h03, 1'b1);
      rd(FBP_SRC_DATA, 13'h0205, 32'h1234_0003, 1'b0);
      $display("read-only test done");
   endtask
   task automatic t_xo();
      prog(13'h0405, 32'h0, 1'b1);
      erase(5'h04, 1'b1);
      rd(FBP_SRC_FETCH, 13'h0405, 32'hC3C3_0004, 1'b0);
      rd(FBP_SRC_DATA, 13'h0405, FBP_ZERO, 1'b1);
      rd(FBP_SRC_DBG, 13'h0405, FBP_ZERO, 1'b1);
      chk(viol_o, 1'b1);
      @(negedge clk_sys_i);
      viol_clr_i = 1'b1;
      @(negedge clk_sys_i);
      viol_clr_i = 1'b0;
      chk(viol_o, 1'b0);
      $display("execute-only test done");
   endtask
   // Unit 0 gets the spare code 3, which must behave as open
   task automatic t_erase();
      setp(32'h0000_0027);
      erase(5'h00, 1'b0);
      rd(FBP_SRC_DATA, 13'h0005, FBP_ERASED, 1'b0);
      rd(FBP_SRC_DATA, 13'h00FF, FBP_ERASED, 1'b0);
      rd(FBP_SRC_DATA, 13'h0105, 32'h5A5A_0002, 1'b0);
      $display("erase test done");
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      t_open();
      t_ro();
      t_xo();
      t_erase();
      results();
   end
endmodule
